// ---- mxb_pkg.sv ----
/*
  mxb_pkg: shared constants and carrier types for the multiplexed external
  memory bus master. Assumes a single 40 MHz clock and no software registers.
*/
package mxb_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned WAIT_W          = 4;
  localparam logic [15:0] VEC_LO_ADDR     = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR     = 16'h0001;
  localparam logic [15:0] ONCHIP_RAM_TOP  = 16'h00ff;
  localparam int unsigned AS_PHASE_CYC    = 1;
  localparam int unsigned DS_PHASE_CYC    = 1;
  localparam logic [3:0]  WAIT_RST        = 4'h0;

  typedef enum logic [2:0] {
    mxb_idle_st  = 3'b000,
    mxb_addr_st  = 3'b001,
    mxb_setup_st = 3'b011,
    mxb_data_st  = 3'b010,
    mxb_wait_st  = 3'b110,
    mxb_end_st   = 3'b100,
    mxb_hand_st  = 3'b101
  } mxb_state_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              program_space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mxb_req_s;

  typedef struct packed {
    logic              addr_strobe_n;
    logic              data_strobe_n;
    logic              read_write;
    logic              prog_data_sel;
    logic [DATA_W-1:0] muxed_addr_data;
    logic [DATA_W-1:0] addr_high;
    logic              muxed_oe;
    logic              ctrl_oe;
  } mxb_pins_s;
endpackage

// ---- mxb_wait_cnt.sv ----
/*
  mxb_wait_cnt: counts programmed wait cycles plus external wait cycles.
  Assumes the wait input is synchronous and active low.
*/
`timescale 1ns/1ps
module mxb_wait_cnt #(
  parameter int unsigned WIDTH = mxb_pkg::WAIT_W
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] prog_waits,
  input  wire logic             ext_wait_n,
  input  wire logic             active,
  // status
  output logic                  done
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("mxb_wait_cnt: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] left;
  } mxb_wc_s;

  mxb_wc_s st_r;
  mxb_wc_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.left = prog_waits;
    end else if (active && st_r.left != '0 && ext_wait_n) begin
      st_nxt.left = st_r.left - 1'b1;
    end
  end

  // wait low freezes the programmed count, so the two kinds of wait add up
  assign done = active && st_r.left == '0 && ext_wait_n;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- mxb_master.sv ----
/*
  mxb_master: master end of an 8-bit multiplexed address/data external memory
  bus with upper address byte, strobes, direction line, wait stretching, bus
  hand-over and the reset vector fetch. Assumes synchronous pin inputs, one
  40 MHz clock, and a core that holds a request until it sees done.
  The pins struct carries output values and two enables; the pad ring
  turns a low enable into high impedance. Read data comes back on a
  separate input, already resolved from the shared lines.
*/
`timescale 1ns/1ps
// How it works
// - address strobe pulses low once at the start of each external cycle.
// - address, direction and space select are valid before address strobe rises.
// - a float control tri-states strobes, direction line and both address ports.
// - write data is driven on the shared lines before data strobe falls.
// - data strobe stays high through cycles that hit on-chip data memory.
// - direction line is low only for writes, high otherwise.
// - after reset the start address is fetched from locations 00h and 01h.
// - eight shared lines carry low address, then data.
// - shared line n carries address bit n, then data bit n.
// - each cycle is stretched by programmed plus external wait cycles.
// - bus request gets grant and release; withdrawal ends grant and redrives.
module mxb_master #(
  parameter int unsigned WAIT_W = mxb_pkg::WAIT_W
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // core request side
  input  wire mxb_pkg::mxb_req_s          req,
  output logic                            done,
  output logic [mxb_pkg::DATA_W-1:0]      rdata,
  output logic                            start_valid,
  output logic [mxb_pkg::ADDR_W-1:0]      start_addr,
  // configuration
  input  wire logic [WAIT_W-1:0]          prog_waits,
  input  wire logic                       bus_float,
  // external bus pins
  output mxb_pkg::mxb_pins_s              pins,
  input  wire logic [mxb_pkg::DATA_W-1:0] muxed_addr_data_in,
  input  wire logic                       ext_wait_n,
  input  wire logic                       ext_bus_request_n,
  output logic                            ext_bus_grant_n
);
  // the wait counter is at most one byte wide
  if (WAIT_W < 1 || WAIT_W > 8) begin : g_bad_wait_w
    $error("mxb_master: WAIT_W out of range");
  end
  // the address leaves as two bytes: low on the shared lines, high on port 1
  if (mxb_pkg::ADDR_W != 2 * mxb_pkg::DATA_W) begin : g_bad_split
    $error("mxb_master: address must be two data bytes");
  end

  typedef struct packed {
    mxb_pkg::mxb_state_e         state;
    mxb_pkg::mxb_req_s           cur;
    logic                        internal;
    logic                        vec_phase;
    logic                        vec_busy;
    logic [mxb_pkg::ADDR_W-1:0]  vec;
    logic                        start_valid;
    logic [mxb_pkg::DATA_W-1:0]  rdata;
    logic                        done;
    logic                        granted;
    mxb_pkg::mxb_pins_s          pins;
  } mxb_st_s;

  mxb_st_s st_r;
  mxb_st_s st_nxt;
  logic    wait_load;
  logic    wait_active;
  logic    wait_done;
  logic    [mxb_pkg::DATA_W-1:0] wr_bits;

  // reads keep the shared-line register low so no stale write data lingers
  for (genvar b = 0; b < mxb_pkg::DATA_W; b++) begin : g_wr_line
    assign wr_bits[b] = st_r.cur.write && st_r.cur.wdata[b];
  end

  mxb_wait_cnt #(.WIDTH(WAIT_W)) u_wait (
    .clock      (clock),
    .reset      (reset),
    .load       (wait_load),
    .prog_waits (prog_waits),
    .ext_wait_n (ext_wait_n),
    .active     (wait_active),
    .done       (wait_done)
  );

  assign wait_load   = st_r.state == mxb_pkg::mxb_addr_st;
  assign wait_active = st_r.state == mxb_pkg::mxb_wait_st;

  always_comb begin
    mxb_pkg::mxb_req_s pick;
    pick   = req;
    st_nxt = st_r;
    // done is a single-cycle pulse
    st_nxt.done = 1'b0;
    // the vector fetch takes the place of any core request until both bytes are in
    if (st_r.vec_busy) begin
      pick.valid         = 1'b1;
      pick.write         = 1'b0;
      pick.program_space = 1'b1;
      pick.addr          = st_r.vec_phase ? mxb_pkg::VEC_LO_ADDR : mxb_pkg::VEC_HI_ADDR;
      pick.wdata         = '0;
    end

    unique case (st_r.state)
      mxb_pkg::mxb_idle_st: begin
        st_nxt.pins.addr_strobe_n = 1'b1;
        st_nxt.pins.data_strobe_n = 1'b1;
        st_nxt.pins.read_write    = 1'b1;
        if (!ext_bus_request_n) begin
          st_nxt.state   = mxb_pkg::mxb_hand_st;
          st_nxt.granted = 1'b1;
        end else if (pick.valid && !(req.valid && st_r.done)) begin
          // a request still up beside done is the one just served, hence the skip
          st_nxt.cur      = pick;
          st_nxt.internal = !pick.program_space && pick.addr <= mxb_pkg::ONCHIP_RAM_TOP;
          st_nxt.state    = mxb_pkg::mxb_addr_st;
          st_nxt.pins.addr_strobe_n   = 1'b0;
          st_nxt.pins.muxed_addr_data = pick.addr[7:0];
          st_nxt.pins.addr_high       = pick.addr[15:8];
          st_nxt.pins.read_write      = !pick.write;
          st_nxt.pins.prog_data_sel   = pick.program_space;
          st_nxt.pins.muxed_oe        = 1'b1;
        end
      end

      mxb_pkg::mxb_addr_st: begin
        // strobe rises with address, direction and space held steady
        st_nxt.pins.addr_strobe_n = 1'b1;
        st_nxt.state = mxb_pkg::mxb_setup_st;
      end

      mxb_pkg::mxb_setup_st: begin
        // write data goes out one cycle before the data strobe falls
        st_nxt.pins.muxed_addr_data = wr_bits;
        st_nxt.pins.muxed_oe        = st_r.cur.write;
        st_nxt.state = mxb_pkg::mxb_data_st;
      end

      mxb_pkg::mxb_data_st: begin
        // on-chip data cycles keep the strobe idle so outside memory never answers
        st_nxt.pins.data_strobe_n = st_r.internal;
        st_nxt.state = mxb_pkg::mxb_wait_st;
      end

      mxb_pkg::mxb_wait_st: begin
        // held here while programmed or external waits remain
        if (wait_done) begin
          st_nxt.pins.data_strobe_n = 1'b1;
          st_nxt.state = mxb_pkg::mxb_end_st;
          // read data taken on the strobe's rising edge
          if (!st_r.cur.write) begin
            st_nxt.rdata = muxed_addr_data_in;
          end
        end
      end

      mxb_pkg::mxb_end_st: begin
        // shared lines let go one cycle after the strobe rises, giving write hold time
        st_nxt.pins.muxed_oe   = 1'b0;
        st_nxt.pins.read_write = 1'b1;
        st_nxt.state = mxb_pkg::mxb_idle_st;
        if (st_r.vec_busy) begin
          if (st_r.vec_phase) begin
            st_nxt.vec[7:0]    = st_r.rdata;
            st_nxt.vec_busy    = 1'b0;
            st_nxt.start_valid = 1'b1;
          end else begin
            st_nxt.vec[15:8]   = st_r.rdata;
            st_nxt.vec_phase   = 1'b1;
          end
        end else begin
          st_nxt.done = 1'b1;
        end
      end

      mxb_pkg::mxb_hand_st: begin
        // every memory pin stays released until the request is withdrawn
        if (ext_bus_request_n) begin
          st_nxt.granted = 1'b0;
          st_nxt.state   = mxb_pkg::mxb_idle_st;
        end
      end
      default: st_nxt.state = mxb_pkg::mxb_idle_st;
    endcase
    // float may land mid-cycle; the cycle still runs so the core is never left hanging
    // float and hand-over release every memory pin together
    st_nxt.pins.ctrl_oe = !bus_float && !st_nxt.granted;
    if (!st_nxt.pins.ctrl_oe) begin
      st_nxt.pins.muxed_oe = 1'b0;
    end
  end

  // one register for the whole state struct; the outputs below are wires to it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r             <= '0;
      st_r.state       <= mxb_pkg::mxb_idle_st;
      // the start address is owed from the first cycle after reset
      st_r.vec_busy    <= 1'b1;
      st_r.pins        <= '0;
      st_r.pins.addr_strobe_n <= 1'b1;
      st_r.pins.data_strobe_n <= 1'b1;
      st_r.pins.read_write    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output comes straight from a flip-flop
  assign pins            = st_r.pins;
  assign done            = st_r.done;
  assign rdata           = st_r.rdata;
  assign start_valid     = st_r.start_valid;
  assign start_addr      = st_r.vec;
  assign ext_bus_grant_n = !st_r.granted;
endmodule

// ---- mxb_checker.sv ----
/*
  mxb_checker: pin-level assertions for mxb_master.
  Assumes a bind to the master; sees only its ports.
*/
`timescale 1ns/1ps
module mxb_checker (
  // clock and reset
  input wire logic               clock,
  input wire logic               reset,
  // watched ports
  input wire logic               bus_float,
  input wire mxb_pkg::mxb_pins_s pins,
  input wire logic               ext_bus_grant_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_go; $fell(pins.addr_strobe_n); endsequence
  sequence s_ram; s_go ##0 (!pins.prog_data_sel && pins.addr_high == 8'h00); endsequence
  property p_as; s_go |=> pins.addr_strobe_n [*3]; endproperty
  a_as: assert property (p_as) else $error("address strobe pulse too long");
  property p_hold; s_go |=> $stable({pins.addr_high, pins.prog_data_sel, pins.read_write}) [*4]; endproperty
  a_hold: assert property (p_hold) else $error("address or direction moved");
  property p_mux; s_go |-> pins.muxed_oe ##1 $stable(pins.muxed_addr_data); endproperty
  a_mux: assert property (p_mux) else $error("low address not held");
  property p_flt; bus_float |=> !pins.ctrl_oe && !pins.muxed_oe; endproperty
  a_flt: assert property (p_flt) else $error("float ignored");
  property p_wd; $fell(pins.data_strobe_n) && !pins.read_write |-> pins.muxed_oe && $stable(pins.muxed_addr_data);
  endproperty
  a_wd: assert property (p_wd) else $error("write data late");
  property p_ram; s_ram |-> pins.data_strobe_n [*5]; endproperty
  a_ram: assert property (p_ram) else $error("data strobe on on-chip access");
  property p_rw; pins.ctrl_oe && !pins.read_write |-> pins.muxed_oe; endproperty
  a_rw: assert property (p_rw) else $error("direction low outside write");
  property p_gnt; !ext_bus_grant_n |-> !pins.ctrl_oe && !pins.muxed_oe; endproperty
  a_gnt: assert property (p_gnt) else $error("bus driven while granted");
endmodule

// ---- mxb_mem_model.sv ----
/*
  mxb_mem_model: behavioural program and data memory on the muxed bus.
  Assumes the master's registered pins and the shared clock.
*/
`timescale 1ns/1ps
module mxb_mem_model (
  // clock, master pins and slow-cycle wait length
  input  wire logic               clock,
  input  wire mxb_pkg::mxb_pins_s pins,
  input  wire logic [3:0]         slow_cyc,
  // resolved shared lines and wait
  output logic [7:0]              bus_in,
  output logic                    wait_n
);
  logic [7:0]  last, mem [0:65535];
  logic [15:0] addr_l;
  logic        prev_as = 1'b1, prev_ds = 1'b1;
  int          wcnt = 0;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h3c;
    mem[0] = 8'h34;
    mem[1] = 8'h12;
    last = 8'h00;
    wait_n = 1'b1;
  end
  // released lines toggle every cycle so a stale sample cannot match
  always @* bus_in = pins.muxed_oe ? pins.muxed_addr_data :
    (!pins.data_strobe_n && pins.read_write) ? mem[addr_l] : ~last;
  always @(posedge clock) begin
    if (pins.addr_strobe_n && !prev_as) begin
      addr_l = {pins.addr_high, pins.muxed_addr_data};
      wcnt = slow_cyc;
    end else if (wcnt > 0) wcnt--;
    if (pins.data_strobe_n && !prev_ds && !pins.read_write) mem[addr_l] = pins.muxed_addr_data;
    prev_as = pins.addr_strobe_n;
    prev_ds = pins.data_strobe_n;
    last <= bus_in;
    wait_n <= (wcnt == 0);
  end
endmodule

// ---- muxed_external_memory_bus_tb_top.sv ----
/*
  bench top: directed scenarios for mxb_master against the memory model.
  Assumes package, design, checker and model are compiled first.
*/
`timescale 1ns/1ps
module muxed_external_memory_bus_tb_top;
  logic               clock, reset, bus_float, breq_n, done, start_valid, grant_n, wait_n;
  logic [3:0]         prog_waits, slow_cyc;
  logic [7:0]         rdata, bus_in;
  logic [15:0]        start_addr;
  mxb_pkg::mxb_req_s  req;
  mxb_pkg::mxb_pins_s pins;
  int                 n_fail, check_count, cyc, n, n0;
  mxb_master dut (.clock(clock), .reset(reset), .req(req), .done(done), .rdata(rdata), .start_valid(start_valid),
    .start_addr(start_addr), .prog_waits(prog_waits), .bus_float(bus_float), .pins(pins),
    .muxed_addr_data_in(bus_in), .ext_wait_n(wait_n), .ext_bus_request_n(breq_n), .ext_bus_grant_n(grant_n));
  mxb_mem_model mem_i (.clock(clock), .pins(pins), .slow_cyc(slow_cyc), .bus_in(bus_in), .wait_n(wait_n));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // lengths are compared against a measured zero-wait baseline, not an absolute figure
  task automatic op(logic wr, logic prog, logic [15:0] a, logic [7:0] d);
    @(posedge clock) #1 req <= '{1'b1, wr, prog, a, d};
    n = 0;
    do begin
      @(posedge clock) #1 n++;
    end while (done !== 1'b1 && n < 60);
    check("cycle done", 16'h0001, 16'(done));
    req.valid <= 1'b0;
  endtask
  task automatic t_vector;
    repeat (40) if (start_valid !== 1'b1) @(posedge clock) #1;
    check("start valid", 16'h0001, 16'(start_valid));
    check("start address", 16'h1234, start_addr);
    $display("test vector done");
  endtask
  task automatic t_rw;
    op(1'b1, 1'b0, 16'h1234, 8'ha5);
    n0 = n;
    check("data write", 16'h00a5, 16'(mem_i.mem[16'h1234]));
    op(1'b0, 1'b0, 16'h1234, 8'h00);
    check("data read", 16'h00a5, 16'(rdata));
    op(1'b1, 1'b1, 16'h8001, 8'h5a);
    op(1'b0, 1'b1, 16'h8001, 8'h00);
    check("program read", 16'h005a, 16'(rdata));
    op(1'b1, 1'b0, 16'h00ff, 8'h77);
    check("on-chip write", 16'h00c3, 16'(mem_i.mem[16'h00ff]));
    $display("test read write done");
  endtask
  task automatic t_wait;
    prog_waits <= 4'h3;
    op(1'b0, 1'b1, 16'h8001, 8'h00);
    check("programmed waits", 16'(n0 + 3), 16'(n));
    prog_waits <= 4'h0;
    slow_cyc <= 4'h6;
    op(1'b0, 1'b1, 16'h8001, 8'h00);
    check("external wait", 16'h0001, 16'(n > n0));
    check("slow read", 16'h005a, 16'(rdata));
    slow_cyc <= 4'h0;
    $display("test waits done");
  endtask
  task automatic t_release;
    bus_float <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("float", 16'h0000, 16'({pins.ctrl_oe, pins.muxed_oe}));
    bus_float <= 1'b0;
    breq_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check("grant", 16'h0000, 16'({grant_n, pins.ctrl_oe}));
    breq_n <= 1'b1;
    op(1'b0, 1'b1, 16'h8001, 8'h00);
    check("redrive", 16'h005a, 16'(rdata));
    check("grant off", 16'h0001, 16'(grant_n));
    $display("test release done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    bus_float = 1'b0;
    breq_n = 1'b1;
    prog_waits = 4'h0;
    slow_cyc = 4'h0;
    req = '0;
    repeat (8) @(posedge clock);
    #1 reset = 1'b0;
    t_vector();
    t_rw();
    t_wait();
    t_release();
    give_verdict();
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
bind mxb_master mxb_checker chk (.clock(clock), .reset(reset), .bus_float(bus_float), .pins(pins),
  .ext_bus_grant_n(ext_bus_grant_n));
